// >>> design/sqsm_core.sv
// command interpreter: status, queries and shared-memory window control
// What this block does
// - calibration query returns stored date text, up to 10 characters.
// - model query returns protected, unchangeable model identifier.
// - serial query returns protected serial text, up to 10 characters.
// - shared memory active detaches processor, backplane owns waveform memory.
// - address auto-increments; controller loads base before any sequence.
// - direction selects read (default) or write; nothing shared until on.
// - normal commands refused while shared; control returns after transfer.
// - direction query gives WRIT or READ; state query gives 0, since it is refused while shared.
// - self-test queries return 0 on pass, nonzero fault code otherwise.
// - clear-status zeroes summary, error and event registers and flushes output queue.
// - event-enable mask 0-255, default 0, query returns it.
// - event-status query returns standard event register 0-255.
// - identity gives four comma fields; ASCII 0 where unavailable.
// - operation-complete query queues 1 after prior commands; bit untouched.
// - reply wait holds bus and handshake off until response exists.
// - options query returns 0 or 2 for enlarged memory.
// - reset command restores all settings to factory defaults.
// - service-request mask ignores bit 6; query never shows it.
// - status-byte query equals serial poll but keeps request bit.
// - bus trigger fires only in trigger/burst mode with bus source.
// - status bit 4 set whenever output queue not empty.
// - event bits latch; cleared only by read or clear-status.
// - status bit 5 is OR of enabled standard events.
`timescale 1ns/1ns
module sqsm_core
  import sqsm_pkg::*;
#(
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic                sys_clk,
  input  wire logic                nrst,
  // command port
  input  wire logic                cmd_valid,
  output logic                     cmd_ready,
  input  wire logic [CMD_W-1:0]    cmd_code,
  input  wire logic [7:0]          cmd_arg,
  // reply bytes
  output logic                     rsp_valid,
  input  wire logic                rsp_ready,
  output logic [7:0]               rsp_data,
  // stored text, held in protected storage outside
  input  wire logic [8*TEXT_LEN-1:0] cal_text,
  input  wire logic [8*TEXT_LEN-1:0] model_text,
  input  wire logic [8*TEXT_LEN-1:0] serial_text,
  input  wire logic                big_mem_fitted,
  // instrument side
  input  wire logic                ops_busy,
  input  wire logic [7:0]          self_test_code,
  input  wire logic [7:0]          err_events,
  input  wire logic                trig_mode_ok,
  input  wire logic                trig_src_bus,
  output logic                     soft_trig,
  output logic                     settings_rst,
  output logic                     err_clr,
  // backplane shared window
  input  wire logic                bp_cycle,
  input  wire logic                bp_base_ld,
  input  wire logic [SMEM_AW-1:0]  bp_base,
  input  wire logic                bp_done,
  output logic                     shared_window_control,
  output logic                     smem_dir_writ,
  output logic                     cpu_detached,
  output logic [SMEM_AW-1:0]       smem_addr,
  // status
  output logic [7:0]               status_byte,
  output logic                     service_request_flag
);
  typedef enum logic [1:0] {S_IDLE, S_WAIT, S_EMIT} sqsm_st_e;
  localparam int ML = 4 + 1 + TEXT_LEN + 4;

  sqsm_st_e            st_q;
  logic [7:0]          ese_q;
  logic [7:0]          sre_q;
  logic [7:0]          esr_q;
  logic                smode_q;
  logic                sstate_q;
  logic [SMEM_AW-1:0]  addr_q;
  logic [7:0]          msg_q [ML];
  logic [4:0]          len_q;
  logic [4:0]          idx_q;
  logic                pend_opc_q;
  logic                pend_opcq_q;
  logic                fifo_flush;
  logic                f_in_valid;
  logic                f_in_ready;
  logic                f_out_valid;
  logic                take;
  logic                is_cmd;
  logic                esb;
  logic [7:0]          stb_core;

  function automatic logic [7:0] tx_byte(input logic [8*TEXT_LEN-1:0] s,
                                         input int i);
    tx_byte = s[8*(TEXT_LEN-1-i) +: 8];
  endfunction

  // text field length, trailing nulls dropped
  function automatic logic [4:0] tx_len(input logic [8*TEXT_LEN-1:0] s);
    tx_len = '0;
    for (int i = 0; i < TEXT_LEN; i++) begin
      if (tx_byte(s, i) != 8'h00) begin
        tx_len = 5'(i + 1);
      end
    end
  endfunction

  sqsm_fifo #(.W(8), .D(DEPTH)) u_queue (
    .sys_clk   (sys_clk),
    .nrst      (nrst),
    .flush     (fifo_flush),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .in_data   (msg_q[idx_q]),
    .out_valid (f_out_valid),
    .out_ready (rsp_ready),
    .out_data  (rsp_data)
  );
  assign rsp_valid  = f_out_valid;
  assign f_in_valid = (st_q == S_EMIT) && (len_q != '0);

  // shared window blocks everything but turning it back off
  assign cmd_ready = (st_q == S_IDLE) &&
                     (!sstate_q || cmd_code == SQSM_CMD_SSTATE);
  assign take   = cmd_valid && cmd_ready;
  assign is_cmd = take;

  assign esb      = |(esr_q & ese_q);
  assign stb_core = {1'b0, 1'b0, esb, f_out_valid, 4'h0};
  assign service_request_flag = |(stb_core & sre_q & SRE_MASK);
  assign status_byte = stb_core | {1'b0, service_request_flag, 6'h00};

  assign fifo_flush = is_cmd && cmd_code == SQSM_CMD_CLS;
  assign err_clr    = fifo_flush;
  assign settings_rst = is_cmd && cmd_code == SQSM_CMD_RST;
  assign soft_trig  = is_cmd && cmd_code == SQSM_CMD_TRG &&
                      trig_mode_ok && trig_src_bus;

  assign shared_window_control = sstate_q;
  assign smem_dir_writ = smode_q;
  assign cpu_detached  = sstate_q;
  assign smem_addr     = addr_q;

  // settings
  always_ff @(posedge sys_clk) begin
    if (!nrst || settings_rst) begin
      ese_q   <= ESE_RST;
      sre_q   <= SRE_RST;
      smode_q <= SMODE_READ;
    end else if (is_cmd) begin
      case (cmd_code)
        SQSM_CMD_ESE:   ese_q   <= cmd_arg;
        SQSM_CMD_SRE:   sre_q   <= cmd_arg & SRE_MASK;
        SQSM_CMD_SMODE: smode_q <= cmd_arg[0];
        default:        ;
      endcase
    end
  end

  // shared state; transfer end hands memory back
  always_ff @(posedge sys_clk) begin
    if (!nrst || settings_rst) begin
      sstate_q <= 1'b0;
    end else if (is_cmd && cmd_code == SQSM_CMD_SSTATE) begin
      sstate_q <= cmd_arg[0];
    end else if (sstate_q && bp_done) begin
      sstate_q <= 1'b0;
    end
  end

  // auto-increment address; cycles count only while shared
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      addr_q <= '0;
    end else if (bp_base_ld) begin
      addr_q <= bp_base;
    end else if (sstate_q && bp_cycle) begin
      addr_q <= addr_q + 1'b1;
    end
  end

  // standard event register: set beats clear
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      esr_q <= ESR_PON;
    end else begin
      logic [7:0] set_v;
      logic       clr_v;
      set_v = err_events;
      set_v[ESR_OPC_BIT] = pend_opc_q && !ops_busy;
      set_v[ESR_QYE_BIT] = err_events[ESR_QYE_BIT];
      clr_v = is_cmd && (cmd_code == SQSM_CMD_CLS ||
                         cmd_code == SQSM_CMD_ESR_Q);
      esr_q <= (clr_v ? 8'h00 : esr_q) | set_v;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      pend_opc_q <= 1'b0;
    end else if (is_cmd && cmd_code == SQSM_CMD_OPC) begin
      pend_opc_q <= 1'b1;
    end else if (!ops_busy) begin
      pend_opc_q <= 1'b0;
    end
  end

  // reply builder
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      st_q        <= S_IDLE;
      len_q       <= '0;
      idx_q       <= '0;
      pend_opcq_q <= 1'b0;
      for (int i = 0; i < ML; i++) begin
        msg_q[i] <= 8'h00;
      end
    end else begin
      case (st_q)
        S_IDLE: begin
          idx_q <= '0;
          if (is_cmd) begin
            st_q <= S_EMIT;
            len_q <= 5'd1;
            case (cmd_code)
              SQSM_CMD_CAL_Q: begin
                len_q <= tx_len(cal_text);
                for (int i = 0; i < TEXT_LEN; i++)
                  msg_q[i] <= tx_byte(cal_text, i);
              end
              SQSM_CMD_MODEL_Q: begin
                len_q <= tx_len(model_text);
                for (int i = 0; i < TEXT_LEN; i++)
                  msg_q[i] <= tx_byte(model_text, i);
              end
              SQSM_CMD_SERIAL_Q: begin
                len_q <= tx_len(serial_text);
                for (int i = 0; i < TEXT_LEN; i++)
                  msg_q[i] <= tx_byte(serial_text, i);
              end
              SQSM_CMD_SMODE_Q: begin
                len_q <= 5'd4;
                for (int i = 0; i < 4; i++)
                  msg_q[i] <= smode_q ? TXT_WRIT[8*(3-i) +: 8]
                                      : TXT_READ[8*(3-i) +: 8];
              end
              SQSM_CMD_SSTATE_Q: msg_q[0] <= sstate_q ? CH_ONE : CH_ZERO;
              SQSM_CMD_TEST_Q:   msg_q[0] <= self_test_code;
              SQSM_CMD_ESE_Q:    msg_q[0] <= ese_q;
              SQSM_CMD_ESR_Q:    msg_q[0] <= esr_q;
              SQSM_CMD_SRE_Q:    msg_q[0] <= sre_q & SRE_MASK;
              SQSM_CMD_STB_Q,
              SQSM_CMD_SPOLL:    msg_q[0] <= status_byte;
              SQSM_CMD_OPT_Q:
                msg_q[0] <= big_mem_fitted ? CH_TWO : CH_ZERO;
              SQSM_CMD_OPC_Q: begin
                msg_q[0]    <= CH_ONE;
                pend_opcq_q <= 1'b1;
                st_q        <= S_WAIT;
              end
              SQSM_CMD_IDN_Q: begin
                len_q <= 5'd4 + 5'd1 + tx_len(model_text) + 5'd4;
                for (int i = 0; i < 4; i++)
                  msg_q[i] <= MAKER_TXT[8*(3-i) +: 8];
                msg_q[4] <= CH_COMMA;
                for (int i = 0; i < TEXT_LEN; i++)
                  msg_q[5+i] <= tx_byte(model_text, i);
                msg_q[5+tx_len(model_text)]   <= CH_COMMA;
                msg_q[5+tx_len(model_text)+1] <= CH_ZERO;
                msg_q[5+tx_len(model_text)+2] <= CH_COMMA;
                msg_q[5+tx_len(model_text)+3] <= CH_ZERO;
              end
              default: st_q <= S_IDLE;
            endcase
          end
        end
        S_WAIT: begin
          // answer held back, and the port with it, until work is done
          if (!ops_busy) begin
            pend_opcq_q <= 1'b0;
            st_q        <= S_EMIT;
          end
        end
        S_EMIT: begin
          if (len_q == '0) begin
            st_q <= S_IDLE;
          end else if (f_in_ready) begin
            // full queue stalls the builder rather than dropping bytes
            idx_q <= idx_q + 1'b1;
            if (idx_q + 1'b1 >= len_q) begin
              st_q <= S_IDLE;
            end
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  property p_mav;
    @(posedge sys_clk) disable iff (!nrst)
      f_in_valid && f_in_ready |=> status_byte[STB_MAV_BIT];
  endproperty
  a_mav: assert property (p_mav) else $error("mav mismatch");

  property p_sre6;
    @(posedge sys_clk) disable iff (!nrst) !sre_q[STB_RQS_BIT];
  endproperty
  a_sre6: assert property (p_sre6) else $error("sre bit6 set");

  property p_refuse;
    @(posedge sys_clk) disable iff (!nrst)
      sstate_q && cmd_code != SQSM_CMD_SSTATE |-> !cmd_ready;
  endproperty
  a_refuse: assert property (p_refuse) else $error("took cmd");

  property p_trg;
    @(posedge sys_clk) disable iff (!nrst)
      soft_trig |-> trig_mode_ok && trig_src_bus;
  endproperty
  a_trg: assert property (p_trg) else $error("bad trigger");

  property p_cls;
    @(posedge sys_clk) disable iff (!nrst)
      is_cmd && cmd_code == SQSM_CMD_CLS && err_events == 8'h00 &&
      !(pend_opc_q && !ops_busy) |=> esr_q == 8'h00;
  endproperty
  a_cls: assert property (p_cls) else $error("cls left events");

  property p_latch;
    @(posedge sys_clk) disable iff (!nrst)
      $past(esr_q) != 8'h00 && !$past(is_cmd) |-> (esr_q & $past(esr_q))
        == $past(esr_q);
  endproperty
  a_latch: assert property (p_latch) else $error("event lost");

  property p_esb;
    @(posedge sys_clk) disable iff (!nrst)
      status_byte[STB_ESB_BIT] == |(esr_q & ese_q);
  endproperty
  a_esb: assert property (p_esb) else $error("esb wrong");

  property p_opcq;
    @(posedge sys_clk) disable iff (!nrst)
      st_q == S_WAIT && ops_busy |=> st_q == S_WAIT && !cmd_ready;
  endproperty
  a_opcq: assert property (p_opcq) else $error("opc? early");

  sequence s_opcq_take;
    is_cmd && cmd_code == SQSM_CMD_OPC_Q;
  endsequence
  sequence s_opcq_held;
    st_q == S_WAIT && pend_opcq_q && !cmd_ready;
  endsequence
  property p_opcq_hold;
    @(posedge sys_clk) disable iff (!nrst) s_opcq_take |=> s_opcq_held;
  endproperty
  a_opcq_hold: assert property (p_opcq_hold) else $error("no hold");

  property p_addr;
    @(posedge sys_clk) disable iff (!nrst)
      sstate_q && bp_cycle && !bp_base_ld |=> addr_q == $past(addr_q) + 1'b1;
  endproperty
  a_addr: assert property (p_addr) else $error("addr no inc");
endmodule

// >>> design/sqsm_fifo.sv
// output queue fifo, parameterised width and depth
`timescale 1ns/1ns
module sqsm_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         nrst,
  input  wire logic         flush,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem_q [D];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0]   cnt_q;
  logic          push;
  logic          pop;

  assign in_ready  = (cnt_q != (AW+1)'(D));
  assign out_valid = (cnt_q != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_q[rd_q];

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst || flush) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(D-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(D-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// >>> design/sqsm_pkg.sv
// constants shared by the status, query and shared-memory core
package sqsm_pkg;
  localparam int CMD_W = 5;
  typedef enum logic [4:0] {
    SQSM_CMD_NOP, SQSM_CMD_CAL_Q, SQSM_CMD_MODEL_Q, SQSM_CMD_SERIAL_Q,
    SQSM_CMD_SMODE, SQSM_CMD_SMODE_Q, SQSM_CMD_SSTATE, SQSM_CMD_SSTATE_Q,
    SQSM_CMD_TEST_Q, SQSM_CMD_CLS, SQSM_CMD_ESE, SQSM_CMD_ESE_Q,
    SQSM_CMD_ESR_Q, SQSM_CMD_IDN_Q, SQSM_CMD_OPC, SQSM_CMD_OPC_Q,
    SQSM_CMD_OPT_Q, SQSM_CMD_RST, SQSM_CMD_SRE, SQSM_CMD_SRE_Q,
    SQSM_CMD_STB_Q, SQSM_CMD_TRG, SQSM_CMD_SPOLL
  } sqsm_cmd_e;
  localparam int          TEXT_LEN    = 10;
  localparam int          SMEM_AW     = 24;
  localparam logic [7:0]  ESE_RST     = 8'h00;
  localparam logic [7:0]  SRE_RST     = 8'h00;
  localparam logic [7:0]  ESR_PON     = 8'h80;
  localparam int          ESR_OPC_BIT = 0;
  localparam int          ESR_QYE_BIT = 2;
  localparam int          STB_MAV_BIT = 4;
  localparam int          STB_ESB_BIT = 5;
  localparam int          STB_RQS_BIT = 6;
  localparam logic [7:0]  SRE_MASK    = 8'hBF;
  localparam logic [7:0]  CH_ZERO     = 8'h30;
  localparam logic [7:0]  CH_ONE      = 8'h31;
  localparam logic [7:0]  CH_TWO      = 8'h32;
  localparam logic [7:0]  CH_COMMA    = 8'h2C;
  localparam logic        SMODE_READ  = 1'b0;
  localparam logic        SMODE_WRIT  = 1'b1;
  // WRIT / READ packed ASCII
  localparam logic [31:0] TXT_WRIT    = 32'h57524954;
  localparam logic [31:0] TXT_READ    = 32'h52454144;
  // arbitrary neutral identity text, not any real part
  localparam logic [31:0] MAKER_TXT   = 32'h4143_4D45;
endpackage

// >>> sim/sqsm_bp_model.sv
// backplane controller model driving the shared memory window
`timescale 1ns/1ns
module sqsm_bp_model
  import sqsm_pkg::*;
(
  // clock
  input  wire logic          sys_clk,
  // backplane cycles
  output logic               bp_cycle,
  output logic               bp_base_ld,
  output logic [SMEM_AW-1:0] bp_base,
  output logic               bp_done
);
  initial begin
    bp_cycle   = 1'b0;
    bp_base_ld = 1'b0;
    bp_base    = 24'h000000;
    bp_done    = 1'b0;
  end
  // base goes first, word cycles only after it
  task automatic load_base(input logic [SMEM_AW-1:0] a);
    @(posedge sys_clk);
    bp_base_ld <= 1'b1;
    bp_base    <= a;
    @(posedge sys_clk);
    bp_base_ld <= 1'b0;
    // released address lines must not look valid
    bp_base    <= ~a;
  endtask
  // gap adds idle edges, so slow masters are covered too
  task automatic words(input int n, input int gap);
    repeat (n) begin
      @(posedge sys_clk);
      bp_cycle <= 1'b1;
      @(posedge sys_clk);
      bp_cycle <= 1'b0;
      repeat (gap) @(posedge sys_clk);
    end
  endtask
  task automatic finish();
    @(posedge sys_clk);
    bp_done <= 1'b1;
    @(posedge sys_clk);
    bp_done <= 1'b0;
  endtask
endmodule

// >>> sim/tb_top.sv
// self-checking bench for the status and shared memory core
`timescale 1ns/1ns
module tb_top
  import sqsm_pkg::*;
;
  logic               sys_clk, nrst, cmd_valid, cmd_ready, rsp_valid;
  logic [CMD_W-1:0]   cmd_code;
  logic [7:0]         cmd_arg, rsp_data, self_test_code, err_events;
  logic               rsp_ready, big_mem_fitted, ops_busy, trig_mode_ok;
  logic               trig_src_bus, soft_trig, settings_rst, err_clr;
  logic [79:0]        cal_text, model_text, serial_text;
  logic               bp_cycle, bp_base_ld, bp_done, shared_window_control;
  logic [SMEM_AW-1:0] bp_base, smem_addr;
  logic               smem_dir_writ, cpu_detached, service_request_flag;
  logic [7:0]         status_byte;
  logic [7:0]         rx[$];
  int                 n_fail = 0, compares = 0;
  int                 n_trig = 0, n_srst = 0, n_clr = 0;

  sqsm_core #(.DEPTH(8)) uut (
    .sys_clk, .nrst, .cmd_valid, .cmd_ready, .cmd_code, .cmd_arg,
    .rsp_valid, .rsp_ready, .rsp_data, .cal_text, .model_text,
    .serial_text, .big_mem_fitted, .ops_busy, .self_test_code,
    .err_events, .trig_mode_ok, .trig_src_bus, .soft_trig,
    .settings_rst, .err_clr, .bp_cycle, .bp_base_ld, .bp_base,
    .bp_done, .shared_window_control, .smem_dir_writ, .cpu_detached,
    .smem_addr, .status_byte, .service_request_flag);
  sqsm_bp_model bp (.sys_clk, .bp_cycle, .bp_base_ld, .bp_base, .bp_done);

  always #5 sys_clk = ~sys_clk;
  // one-cycle strobes are tallied, not sampled once
  always @(posedge sys_clk) begin
    if (soft_trig === 1'b1) n_trig++;
    if (settings_rst === 1'b1) n_srst++;
    if (err_clr === 1'b1) n_clr++;
  end

  task automatic complete_run();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk_f(input string nm, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s exp %b got %b", nm, e, g);
    end
  endtask
  task automatic chk_a(input string nm, input logic [23:0] e,
                       input logic [23:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  // compares the first n reply bytes, text order, top byte first
  task automatic chk_rx(input string nm, input logic [79:0] t, input int n);
    for (int i = 0; i < n; i++) begin
      compares++;
      if (rx[i] !== t[8*(n-i)-1 -: 8]) begin
        n_fail++;
        $display("[ERR] %s exp %h got %h", nm, t[8*(n-i)-1 -: 8], rx[i]);
      end
    end
  endtask
  task automatic send(input sqsm_cmd_e c, input logic [7:0] a);
    int k;
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd_code  <= c;
    cmd_arg   <= a;
    k = 0;
    do begin
      @(negedge sys_clk);
      k++;
    end while (cmd_ready !== 1'b1 && k < 300);
    if (k >= 300) chk_f("cmd_ready", 1'b1, cmd_ready);
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
  endtask
  task automatic recv(input int n);
    int k;
    rx.delete();
    k = 0;
    while (rx.size() < n && k < 400) begin
      @(negedge sys_clk);
      k++;
      if (rsp_valid === 1'b1) rx.push_back(rsp_data);
    end
    if (k >= 400) chk_f("reply_len", 1'b1, 1'b0);
  endtask
  task automatic qry(input sqsm_cmd_e c, input int n);
    send(c, 8'h00);
    recv(n);
  endtask
  task automatic pulse_err(input logic [7:0] v);
    @(posedge sys_clk);
    err_events <= v;
    @(posedge sys_clk);
    err_events <= 8'h00;
    @(negedge sys_clk);
  endtask

  task automatic t_reset();
    chk_f("mav_rst", 1'b0, status_byte[STB_MAV_BIT]);
    chk_f("esb_off", 1'b0, status_byte[STB_ESB_BIT]);
    qry(SQSM_CMD_ESR_Q, 1);
    chk_rx("esr_pon", 80'h80, 1);
    qry(SQSM_CMD_ESR_Q, 1);
    chk_rx("esr_read_clr", 80'h00, 1);
    qry(SQSM_CMD_ESE_Q, 1);
    chk_rx("ese_dflt", 80'h00, 1);
    qry(SQSM_CMD_SRE_Q, 1);
    chk_rx("sre_dflt", 80'h00, 1);
    qry(SQSM_CMD_SMODE_Q, 4);
    chk_rx("dir_dflt", {48'h0, TXT_READ}, 4);
    qry(SQSM_CMD_SSTATE_Q, 1);
    chk_rx("state_off", {72'h0, CH_ZERO}, 1);
  endtask
  task automatic t_text();
    // stalled drain: 10-byte reply overfills the 8-word queue
    @(posedge sys_clk);
    rsp_ready <= 1'b0;
    send(SQSM_CMD_CAL_Q, 8'h00);
    repeat (30) @(negedge sys_clk);
    chk_f("hold_cmd", 1'b0, cmd_ready);
    chk_f("mav_full", 1'b1, status_byte[STB_MAV_BIT]);
    // released on an edge, so the first byte is not popped unseen
    @(posedge sys_clk);
    rsp_ready <= 1'b1;
    recv(10);
    chk_rx("cal", cal_text, 10);
    @(negedge sys_clk);
    chk_f("mav_empty", 1'b0, status_byte[STB_MAV_BIT]);
    qry(SQSM_CMD_MODEL_Q, 10);
    chk_rx("model", model_text, 10);
    qry(SQSM_CMD_SERIAL_Q, 10);
    chk_rx("serial", serial_text, 10);
    qry(SQSM_CMD_IDN_Q, 19);
    chk_rx("idn_maker", {40'h0, MAKER_TXT, CH_COMMA}, 5);
    repeat (5) void'(rx.pop_front());
    chk_rx("idn_model", model_text, 10);
    repeat (10) void'(rx.pop_front());
    chk_rx("idn_tail", {48'h0, CH_COMMA, CH_ZERO, CH_COMMA, CH_ZERO}, 4);
  endtask
  task automatic t_status();
    int t0;
    send(SQSM_CMD_ESE, 8'hFF);
    qry(SQSM_CMD_ESE_Q, 1);
    chk_rx("ese_full", 80'hFF, 1);
    send(SQSM_CMD_SRE, 8'hFF);
    qry(SQSM_CMD_SRE_Q, 1);
    chk_rx("sre_mask", 80'hBF, 1);
    send(SQSM_CMD_ESE, 8'h08);
    pulse_err(8'h08);
    chk_a("stb", 24'h000060, {16'h0, status_byte});
    chk_f("srq", 1'b1, service_request_flag);
    qry(SQSM_CMD_STB_Q, 1);
    chk_rx("stb_q", 80'h60, 1);
    qry(SQSM_CMD_STB_Q, 1);
    chk_rx("stb_q_again", 80'h60, 1);
    qry(SQSM_CMD_SPOLL, 1);
    chk_rx("spoll", 80'h60, 1);
    t0 = n_srst;
    send(SQSM_CMD_RST, 8'h00);
    @(negedge sys_clk);
    chk_a("rst_pulse", 24'h000001, 24'(n_srst - t0));
    qry(SQSM_CMD_ESR_Q, 1);
    chk_rx("esr_after_rst", 80'h08, 1);
    send(SQSM_CMD_ESE, 8'h08);
    pulse_err(8'h08);
    chk_f("esb_set", 1'b1, status_byte[STB_ESB_BIT]);
    t0 = n_clr;
    send(SQSM_CMD_CLS, 8'h00);
    @(negedge sys_clk);
    chk_a("cls_pulse", 24'h000001, 24'(n_clr - t0));
    chk_a("stb_cls", 24'h000000, {16'h0, status_byte});
    qry(SQSM_CMD_ESE_Q, 1);
    chk_rx("ese_kept", 80'h08, 1);
  endtask
  task automatic t_opc();
    send(SQSM_CMD_ESE, 8'h01);
    ops_busy <= 1'b1;
    send(SQSM_CMD_OPC_Q, 8'h00);
    repeat (10) @(negedge sys_clk);
    chk_f("opcq_wait", 1'b0, rsp_valid);
    chk_f("opcq_hold", 1'b0, cmd_ready);
    @(posedge sys_clk);
    ops_busy <= 1'b0;
    recv(1);
    chk_rx("opcq", {72'h0, CH_ONE}, 1);
    chk_f("opcq_no_bit", 1'b0, status_byte[STB_ESB_BIT]);
    @(posedge sys_clk);
    ops_busy <= 1'b1;
    send(SQSM_CMD_OPC, 8'h00);
    repeat (10) @(negedge sys_clk);
    chk_f("opc_wait", 1'b0, status_byte[STB_ESB_BIT]);
    @(posedge sys_clk);
    ops_busy <= 1'b0;
    repeat (5) @(negedge sys_clk);
    chk_f("opc_done", 1'b1, status_byte[STB_ESB_BIT]);
    qry(SQSM_CMD_ESR_Q, 1);
    chk_rx("esr_opc", 80'h01, 1);
  endtask
  task automatic t_misc();
    int t0;
    @(posedge sys_clk);
    self_test_code <= 8'h5A;
    qry(SQSM_CMD_TEST_Q, 1);
    chk_rx("test_fail", 80'h5A, 1);
    @(posedge sys_clk);
    self_test_code <= 8'h00;
    qry(SQSM_CMD_TEST_Q, 1);
    chk_rx("test_pass", 80'h00, 1);
    qry(SQSM_CMD_OPT_Q, 1);
    chk_rx("opt_none", {72'h0, CH_ZERO}, 1);
    @(posedge sys_clk);
    big_mem_fitted <= 1'b1;
    qry(SQSM_CMD_OPT_Q, 1);
    chk_rx("opt_big", {72'h0, CH_TWO}, 1);
    for (int m = 0; m < 4; m++) begin
      @(posedge sys_clk);
      trig_mode_ok <= m[0];
      trig_src_bus <= m[1];
      t0 = n_trig;
      send(SQSM_CMD_TRG, 8'h00);
      @(negedge sys_clk);
      chk_a("trig", {23'h0, m == 3}, 24'(n_trig - t0));
    end
  endtask
  task automatic t_smem();
    send(SQSM_CMD_SMODE, 8'h01);
    @(negedge sys_clk);
    chk_f("dir_writ", 1'b1, smem_dir_writ);
    qry(SQSM_CMD_SMODE_Q, 4);
    chk_rx("dir_q", {48'h0, TXT_WRIT}, 4);
    bp.load_base(24'hFFFFFE);
    bp.words(2, 0);
    @(negedge sys_clk);
    chk_a("addr_idle", 24'hFFFFFE, smem_addr);
    send(SQSM_CMD_SSTATE, 8'h01);
    @(negedge sys_clk);
    chk_f("window_on", 1'b1, shared_window_control);
    chk_f("detached", 1'b1, cpu_detached);
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd_code  <= SQSM_CMD_TEST_Q;
    repeat (3) @(negedge sys_clk);
    chk_f("refused", 1'b0, cmd_ready);
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    bp.load_base(24'hFFFFFE);
    bp.words(4, 1);
    @(negedge sys_clk);
    chk_a("addr_wrap", 24'h000002, smem_addr);
    bp.finish();
    repeat (2) @(negedge sys_clk);
    chk_f("attached", 1'b0, cpu_detached);
    qry(SQSM_CMD_SSTATE_Q, 1);
    chk_rx("state_q", {72'h0, CH_ZERO}, 1);
    send(SQSM_CMD_SMODE, 8'h00);
    qry(SQSM_CMD_SMODE_Q, 4);
    chk_rx("dir_read", {48'h0, TXT_READ}, 4);
  endtask

  initial begin
    sys_clk = 1'b0;
    nrst = 1'b0;
    {cmd_valid, big_mem_fitted, ops_busy, trig_mode_ok} = 4'h0;
    trig_src_bus = 1'b0;
    rsp_ready = 1'b1;
    cmd_code = 5'h00;
    {cmd_arg, self_test_code, err_events} = 24'h000000;
    cal_text = "2006-10-24";
    model_text = "MDL-X12345";
    serial_text = "SN00001234";
    repeat (12) @(posedge sys_clk);
    nrst <= 1'b1;
    @(negedge sys_clk);
    t_reset();
    t_text();
    t_status();
    t_opc();
    t_misc();
    t_smem();
    complete_run();
  end
  // all scenarios fit in a few thousand cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    complete_run();
  end
endmodule
